/* emb_pkg.sv */
`default_nettype none
package emb_pkg;
    // *****************************************
    // register map
    // *****************************************
    localparam logic [31:0] EMB_ROM_CTRL_ADDR = 32'hB000_1004;
    localparam logic [31:0] EMB_SDCFG0_ADDR   = 32'hB000_1008;
    localparam logic [31:0] EMB_SDCFG1_ADDR   = 32'hB000_100C;
    localparam logic [31:0] EMB_SDCFG_RST     = 32'h0000_0800;
    localparam logic [31:0] EMB_SDCFG_WMASK   = 32'hFFF8_38FF;
    localparam logic [7:0]  EMB_ROM_RST       = 8'h00;
    localparam logic [7:0]  EMB_ROM_WMASK     = 8'hF3;

    // *****************************************
    // field positions
    // *****************************************
    localparam int EMB_BASE_HI = 31;
    localparam int EMB_BASE_LO = 19;
    localparam int EMB_MRS_BIT = 15;
    localparam int EMB_APC_BIT = 13;
    localparam int EMB_LAT_HI  = 12;
    localparam int EMB_LAT_LO  = 11;
    localparam int EMB_CBK_BIT = 7;
    localparam int EMB_SIZE_HI = 2;
    localparam int EMB_SIZE_LO = 0;
    localparam int EMB_ACC_HI  = 7;
    localparam int EMB_ACC_LO  = 4;
    localparam int EMB_BW_HI   = 3;
    localparam int EMB_BW_LO   = 2;
    localparam int EMB_PG_HI   = 1;
    localparam int EMB_PG_LO   = 0;

    // *****************************************
    // codes and counts
    // *****************************************
    localparam logic [1:0] EMB_LAT_RESERVED = 2'h3;
    localparam logic [2:0] EMB_SIZE_MAX     = 3'h6;
    localparam logic [4:0] EMB_UNIT_SHIFT   = 5'h12;
    localparam logic [4:0] EMB_CBK_MSB_BASE = 5'h11;
    localparam logic [4:0] EMB_ACC_MIN      = 5'h03;
    localparam logic [4:0] EMB_ACC_LONG     = 5'h0A;
    localparam logic [3:0] EMB_ACC_SHORT    = 4'h3;
    localparam logic [1:0] EMB_BOOT_SETTLE  = 2'h2;
    localparam logic [1:0] EMB_RESP_OKAY    = 2'h0;
    localparam logic [1:0] EMB_RESP_SLVERR  = 2'h2;
    localparam logic [1:0] EMB_SEL_ROM      = 2'h0;
    localparam logic [1:0] EMB_SEL_B0       = 2'h1;
    localparam logic [1:0] EMB_SEL_B1       = 2'h2;
    localparam logic [1:0] EMB_SEL_NONE     = 2'h3;

    typedef struct packed {
        logic [31:0] start;
        logic        auto_pre;
        logic [1:0]  cas_cycles;
        logic        four_cbanks;
    } emb_bank_t;

    typedef struct packed {
        logic [4:0] acc_cycles;
        logic [4:0] page_words;
        logic [1:0] boot_width;
    } emb_rom_t;

    typedef struct packed {
        logic [1:0][31:0]     cfg;
        logic [7:0]           rom;
        logic [1:0]           boot_s1;
        logic [1:0]           boot_s2;
        logic [1:0]           boot_cnt;
        logic                 boot_done;
        logic                 aw_full;
        logic [31:0]          awaddr;
        logic                 w_full;
        logic [31:0]          wdata;
        logic [3:0]           wstrb;
        logic                 awready;
        logic                 wready;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 arready;
        logic                 rvalid;
        logic [31:0]          rdata;
        logic [1:0]           rresp;
        logic [1:0]           mrs_req;
        logic [1:0]           hit;
        logic [1:0]           cbank;
        logic [1:0]           bank_wr;
        emb_bank_t [1:0]      bank;
        emb_rom_t             rom_out;
    } emb_state_t;
endpackage : emb_pkg
`default_nettype wire

/* emb_config.sv */
// Notes on behaviour
// - each of the two SDRAM banks has its own configuration register
// - bank start address is base pointer bits 31..19 shifted left by 18
// - address inside base plus size range is flagged as that bank's hit; where both ranges hold it, only bank 0 is flagged
// - writing 1 to bit 15 requests a mode register set for that bank
// - bit 13 low selects auto pre-charge, high disables it
// - CAS latency code 00/01/10 gives 1/2/3 clocks; code 11 is refused
// - bit 7 selects two or four component banks; bank index follows it
// - boot bus width field is read-only, caught from the strap after reset
// - reset loads both bank registers with 0x0000_0800
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module emb_config
    import emb_pkg::*;
(
    // clock, reset, enable
    input  wire logic              CLK,
    input  wire logic              RST,
    input  wire logic              CE,
    // axi4-lite write
    input  wire logic [31:0]       AWADDR,
    input  wire logic              AWVALID,
    output var  logic              AWREADY,
    input  wire logic [31:0]       WDATA,
    input  wire logic [3:0]        WSTRB,
    input  wire logic              WVALID,
    output var  logic              WREADY,
    output var  logic [1:0]        BRESP,
    output var  logic              BVALID,
    input  wire logic              BREADY,
    // axi4-lite read
    input  wire logic [31:0]       ARADDR,
    input  wire logic              ARVALID,
    output var  logic              ARREADY,
    output var  logic [31:0]       RDATA,
    output var  logic [1:0]        RRESP,
    output var  logic              RVALID,
    input  wire logic              RREADY,
    // memory controller side
    input  wire logic [31:0]       MEM_ADDR,
    input  wire logic [1:0]        MRS_ACK,
    output var  logic [1:0]        MRS_REQ,
    output var  logic [1:0]        BANK_HIT,
    output var  logic [1:0]        MEM_CBANK,
    output var  emb_bank_t [1:0]   BANK_CFG,
    output var  emb_rom_t          ROM_CFG,
    // boot strap pin
    input  wire logic [1:0]        BOOT_WIDTH_PIN
);

    // *****************************************
    // helpers
    // *****************************************
    function automatic logic [1:0] addr_sel(input logic [31:0] a);
        if (a == EMB_ROM_CTRL_ADDR) begin
            addr_sel = EMB_SEL_ROM;
        end else if (a == EMB_SDCFG0_ADDR) begin
            addr_sel = EMB_SEL_B0;
        end else if (a == EMB_SDCFG1_ADDR) begin
            addr_sel = EMB_SEL_B1;
        end else begin
            addr_sel = EMB_SEL_NONE;
        end
    endfunction : addr_sel

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] strb, input logic [31:0] wm);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wm;
        merge = (old & ~m) | (d & m);
    endfunction : merge

    function automatic logic [31:0] start_of(input logic [31:0] c);
        start_of = {1'b0, c[EMB_BASE_HI:EMB_BASE_LO], 18'h00000};
    endfunction : start_of

    // reserved size codes never match
    function automatic logic in_range(input logic [31:0] a, input logic [31:0] c);
        logic [32:0] lo;
        logic [32:0] hi;
        lo = {1'b0, start_of(c)};
        hi = lo + (33'h0_0000_0001 << (EMB_UNIT_SHIFT + {2'h0, c[EMB_SIZE_HI:EMB_SIZE_LO]}));
        in_range = (c[EMB_SIZE_HI:EMB_SIZE_LO] <= EMB_SIZE_MAX)
                   && ({1'b0, a} >= lo) && ({1'b0, a} < hi);
    endfunction : in_range

    // component bank index taken from the top bits of the offset in the bank
    function automatic logic [1:0] cbank_of(input logic [31:0] a, input logic [31:0] c);
        logic [31:0] off;
        logic [4:0]  msb;
        off = a - start_of(c);
        msb = EMB_CBK_MSB_BASE + {2'h0, c[EMB_SIZE_HI:EMB_SIZE_LO]};
        if (c[EMB_CBK_BIT]) begin
            cbank_of = {off[msb], off[msb - 5'h01]};
        end else begin
            cbank_of = {1'b0, off[msb]};
        end
    endfunction : cbank_of

    function automatic logic [4:0] acc_cycles(input logic [3:0] code);
        if (code[3]) begin
            acc_cycles = EMB_ACC_LONG + {1'b0, code[2:0], 1'b0};
        end else if (code < EMB_ACC_SHORT) begin
            acc_cycles = EMB_ACC_MIN;
        end else begin
            acc_cycles = {1'b0, code} + 5'h01;
        end
    endfunction : acc_cycles

    function automatic logic [4:0] page_words(input logic [1:0] pg);
        page_words = (pg == 2'h0) ? 5'h01 : (5'h02 << pg);
    endfunction : page_words

    // *****************************************
    // state update
    // *****************************************
    emb_state_t s;
    emb_state_t n;
    logic [1:0] wsel;
    logic [1:0] rsel;
    logic [31:0] wv;
    logic [31:0] rv;

    always_comb begin
        n = s;
        wsel = addr_sel(s.awaddr);
        rsel = addr_sel(ARADDR);
        wv = 32'h0000_0000;
        rv = 32'h0000_0000;
        n.bank_wr = 2'h0;
        n.boot_s1 = BOOT_WIDTH_PIN;
        n.boot_s2 = s.boot_s1;
        if (!s.boot_done) begin
            if (s.boot_cnt == EMB_BOOT_SETTLE) begin
                n.rom[EMB_BW_HI:EMB_BW_LO] = s.boot_s2;
                n.boot_done = 1'b1;
            end else begin
                n.boot_cnt = s.boot_cnt + 2'h1;
            end
        end
        for (int b = 0; b < 2; b++) begin
            if (MRS_ACK[b]) begin
                n.cfg[b][EMB_MRS_BIT] = 1'b0;
            end
        end
        if (AWVALID && s.awready) begin
            n.aw_full = 1'b1;
            n.awaddr = AWADDR;
        end
        if (WVALID && s.wready) begin
            n.w_full = 1'b1;
            n.wdata = WDATA;
            n.wstrb = WSTRB;
        end
        if (s.bvalid && BREADY) begin
            n.bvalid = 1'b0;
        end
        if (s.aw_full && s.w_full && !s.bvalid) begin
            n.aw_full = 1'b0;
            n.w_full = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = (wsel == EMB_SEL_NONE) ? EMB_RESP_SLVERR : EMB_RESP_OKAY;
            if (wsel == EMB_SEL_ROM) begin
                // start from n.rom so a strap catch in the same cycle is kept
                rv = merge({24'h000000, n.rom}, s.wdata, s.wstrb,
                           {24'h000000, EMB_ROM_WMASK});
                n.rom = rv[7:0];
            end else if (wsel != EMB_SEL_NONE) begin
                for (int b = 0; b < 2; b++) begin
                    if (wsel == (b == 0 ? EMB_SEL_B0 : EMB_SEL_B1)) begin
                        n.bank_wr[b] = 1'b1;
                        wv = merge(s.cfg[b], s.wdata, s.wstrb, EMB_SDCFG_WMASK);
                        // reserved latency code keeps the old field
                        if (wv[EMB_LAT_HI:EMB_LAT_LO] == EMB_LAT_RESERVED) begin
                            wv[EMB_LAT_HI:EMB_LAT_LO] = s.cfg[b][EMB_LAT_HI:EMB_LAT_LO];
                        end
                        // set wins over a same-cycle acknowledge
                        wv[EMB_MRS_BIT] = n.cfg[b][EMB_MRS_BIT]
                                          | (s.wstrb[1] & s.wdata[EMB_MRS_BIT]);
                        n.cfg[b] = wv;
                    end
                end
            end
        end
        if (ARVALID && s.arready) begin
            n.arready = 1'b0;
            n.rvalid = 1'b1;
            n.rresp = EMB_RESP_OKAY;
            if (rsel == EMB_SEL_ROM) begin
                n.rdata = {24'h000000, s.rom};
            end else if (rsel == EMB_SEL_B0) begin
                n.rdata = s.cfg[0];
            end else if (rsel == EMB_SEL_B1) begin
                n.rdata = s.cfg[1];
            end else begin
                n.rdata = 32'h0000_0000;
                n.rresp = EMB_RESP_SLVERR;
            end
        end else if (s.rvalid && RREADY) begin
            n.rvalid = 1'b0;
            n.arready = 1'b1;
        end
        // bank 0 wins where the two ranges overlap
        n.hit[0] = in_range(MEM_ADDR, s.cfg[0]);
        n.hit[1] = in_range(MEM_ADDR, s.cfg[1]) && !n.hit[0];
        if (n.hit[0]) begin
            n.cbank = cbank_of(MEM_ADDR, s.cfg[0]);
        end else if (n.hit[1]) begin
            n.cbank = cbank_of(MEM_ADDR, s.cfg[1]);
        end else begin
            n.cbank = 2'h0;
        end
        if (RST) begin
            n = '0;
            n.cfg[0] = EMB_SDCFG_RST;
            n.cfg[1] = EMB_SDCFG_RST;
            n.rom = EMB_ROM_RST;
            n.arready = 1'b1;
        end
        n.awready = !n.aw_full && !n.bvalid;
        n.wready = !n.w_full && !n.bvalid;
        for (int b = 0; b < 2; b++) begin
            n.mrs_req[b] = n.cfg[b][EMB_MRS_BIT];
            n.bank[b].start = start_of(n.cfg[b]);
            n.bank[b].auto_pre = !n.cfg[b][EMB_APC_BIT];
            n.bank[b].cas_cycles = n.cfg[b][EMB_LAT_HI:EMB_LAT_LO] + 2'h1;
            n.bank[b].four_cbanks = n.cfg[b][EMB_CBK_BIT];
        end
        n.rom_out.acc_cycles = acc_cycles(n.rom[EMB_ACC_HI:EMB_ACC_LO]);
        n.rom_out.page_words = page_words(n.rom[EMB_PG_HI:EMB_PG_LO]);
        n.rom_out.boot_width = n.rom[EMB_BW_HI:EMB_BW_LO];
    end

    always_ff @(posedge CLK) begin
        if (RST || CE) begin
            s <= n;
        end
    end

    assign AWREADY   = s.awready;
    assign WREADY    = s.wready;
    assign BVALID    = s.bvalid;
    assign BRESP     = s.bresp;
    assign ARREADY   = s.arready;
    assign RVALID    = s.rvalid;
    assign RDATA     = s.rdata;
    assign RRESP     = s.rresp;
    assign MRS_REQ   = s.mrs_req;
    assign BANK_HIT  = s.hit;
    assign MEM_CBANK = s.cbank;
    assign BANK_CFG  = s.bank;
    assign ROM_CFG   = s.rom_out;

    // *****************************************
    // checks
    // *****************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    property p_bank_indep;
        s.bank_wr[0] && !$past(MRS_ACK[1]) |-> $stable(s.cfg[1]);
    endproperty
    a_bank_indep: assert property (p_bank_indep) else $error("bank 1 changed on bank 0 write");

    property p_start;
        BANK_CFG[1].start == {1'b0, s.cfg[1][EMB_BASE_HI:EMB_BASE_LO], 18'h00000};
    endproperty
    a_start: assert property (p_start) else $error("bank start address wrong");

    property p_hit;
        $past(CE) && !$past(RST) |-> BANK_HIT[0] == in_range($past(MEM_ADDR), $past(s.cfg[0]));
    endproperty
    a_hit: assert property (p_hit) else $error("bank 0 hit wrong");

    property p_mrs_hold;
        CE && MRS_REQ[0] && !MRS_ACK[0] |=> MRS_REQ[0];
    endproperty
    a_mrs_hold: assert property (p_mrs_hold) else $error("mode set request dropped");

    property p_apc;
        BANK_CFG[0].auto_pre != s.cfg[0][EMB_APC_BIT];
    endproperty
    a_apc: assert property (p_apc) else $error("auto pre-charge select wrong");

    property p_lat;
        s.cfg[0][EMB_LAT_HI:EMB_LAT_LO] != EMB_LAT_RESERVED
        && BANK_CFG[0].cas_cycles == s.cfg[0][EMB_LAT_HI:EMB_LAT_LO] + 2'h1;
    endproperty
    a_lat: assert property (p_lat) else $error("CAS latency wrong");

    property p_cbk;
        $past(CE) && !$past(RST) && BANK_HIT[0] && !$past(s.cfg[0][EMB_CBK_BIT])
            |-> !MEM_CBANK[1];
    endproperty
    a_cbk: assert property (p_cbk) else $error("two-bank index out of range");

    property p_boot_ro;
        s.boot_done |=> $stable(ROM_CFG.boot_width);
    endproperty
    a_boot_ro: assert property (p_boot_ro) else $error("boot width changed");

    property p_rst_val;
        $past(RST) |-> s.cfg[0] == EMB_SDCFG_RST && s.cfg[1] == EMB_SDCFG_RST;
    endproperty
    a_rst_val: assert property (p_rst_val) else $error("reset value wrong");

    property p_page;
        ROM_CFG.page_words == page_words(s.rom[EMB_PG_HI:EMB_PG_LO]);
    endproperty
    a_page: assert property (p_page) else $error("page size wrong");

    property p_acc;
        ROM_CFG.acc_cycles == acc_cycles(s.rom[EMB_ACC_HI:EMB_ACC_LO]);
    endproperty
    a_acc: assert property (p_acc) else $error("access cycles wrong");

    property p_freeze;
        !CE |=> $stable(s);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while disabled");

    property p_c_wr;
        BVALID && BREADY && BRESP == EMB_RESP_OKAY;
    endproperty
    c_wr: cover property (p_c_wr);

    property p_c_rd;
        RVALID && RREADY;
    endproperty
    c_rd: cover property (p_c_rd);

    property p_c_mrs;
        MRS_REQ[1] ##1 MRS_ACK[1];
    endproperty
    c_mrs: cover property (p_c_mrs);

    property p_c_hit;
        BANK_HIT[1] && MEM_CBANK == 2'h3;
    endproperty
    c_hit: cover property (p_c_hit);

    property p_c_freeze;
        !CE && BANK_HIT[1];
    endproperty
    c_freeze: cover property (p_c_freeze);
endmodule : emb_config
`default_nettype wire

/* emb_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
module emb_mem_model
    import emb_pkg::*;
(
    // clock and reset
    input  wire logic       CLK,
    input  wire logic       RST,
    // mode set handshake
    input  wire logic [1:0] MRS_REQ,
    input  wire logic [3:0] ACK_DELAY,
    output var  logic [1:0] MRS_ACK
);
    // ****************************************
    // mode register set completion
    // ****************************************
    logic [1:0][3:0] cnt_q;

    // delay of 0 is not used: the request may stand one edge after the ack
    always_ff @(posedge CLK) begin
        for (int b = 0; b < 2; b++) begin
            MRS_ACK[b] <= 1'b0;
            if (RST || !MRS_REQ[b] || MRS_ACK[b]) begin
                cnt_q[b] <= 4'h0;
            end else if (cnt_q[b] == ACK_DELAY) begin
                MRS_ACK[b] <= 1'b1;
                cnt_q[b]   <= 4'h0;
            end else begin
                cnt_q[b] <= cnt_q[b] + 4'h1;
            end
        end
    end
endmodule : emb_mem_model
`default_nettype wire

/* ext_mem_bank_config_test.sv */
`timescale 1ns/10ps
`default_nettype none
module ext_mem_bank_config_test
    import emb_pkg::*;
;
    logic            clk, rst, ce, awvalid, wvalid, bready, arvalid, rready;
    logic            awready, wready, bvalid, arready, rvalid;
    logic [31:0]     awaddr, wdata, araddr, rdata, mem_addr, rd;
    logic [3:0]      ack_dly, wstrb;
    logic [1:0]      bresp, rresp, mrs_req, mrs_ack, hit, cbank, boot_pin, resp;
    emb_bank_t [1:0] bank_cfg;
    emb_rom_t        rom_cfg;
    int              err_total, n_compared;

    emb_config dut (.CLK(clk), .RST(rst), .CE(ce),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
        .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
        .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
        .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
        .RREADY(rready), .MEM_ADDR(mem_addr), .MRS_ACK(mrs_ack), .MRS_REQ(mrs_req),
        .BANK_HIT(hit), .MEM_CBANK(cbank), .BANK_CFG(bank_cfg), .ROM_CFG(rom_cfg),
        .BOOT_WIDTH_PIN(boot_pin));

    emb_mem_model mem (.CLK(clk), .RST(rst), .MRS_REQ(mrs_req), .ACK_DELAY(ack_dly),
        .MRS_ACK(mrs_ack));

    initial clk = 1'b0;
    always #5 clk = ~clk;

    // ****************************************
    // bus and compare tasks
    // ****************************************
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rdr(input logic [31:0] a);
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd   = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : rdr

    task automatic rchk(input logic [31:0] a, input logic [31:0] e);
        rdr(a);
        chk({4'h0, rd}, {4'h0, e});
    endtask : rchk

    // hit and component bank land one edge after the address; the check waits three
    task automatic hchk(input logic [31:0] a, input logic [3:0] e);
        @(posedge clk);
        mem_addr <= a;
        repeat (3) @(posedge clk);
        chk({32'h0, hit, cbank}, {32'h0, e});
    endtask : hchk

    task automatic report_and_stop();
        $display("compared %0d values, %0d wrong", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (8000) @(posedge clk);
        err_total++;
        report_and_stop();
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        rst = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
        rready = 1'b0; awaddr = 32'h0; wdata = 32'h0; araddr = 32'h0;
        mem_addr = 32'h0; boot_pin = 2'h2; ack_dly = 4'h8;
        ce = 1'b1; wstrb = 4'hF;
        err_total = 0; n_compared = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        rchk(EMB_SDCFG0_ADDR, EMB_SDCFG_RST);
        rchk(EMB_SDCFG1_ADDR, EMB_SDCFG_RST);
        chk(bank_cfg[1], {32'h0, 1'b1, 2'h2, 1'b0});
        rchk(EMB_ROM_CTRL_ADDR, 32'h8);
        chk(36'(rom_cfg.boot_width), 36'h2);
        // width bits written as ones must not stick
        for (int i = 0; i < 16; i++) begin
            wr(EMB_ROM_CTRL_ADDR, 32'(i * 16 + 12 + i % 4));
            @(posedge clk);
            chk(36'(rom_cfg.acc_cycles),
                i < 2 ? 36'h3 : (i < 8 ? 36'(i + 1) : 36'(10 + 2 * (i - 8))));
            chk(36'(rom_cfg.page_words), i % 4 == 0 ? 36'h1 : 36'(2 << (i % 4)));
            rchk(EMB_ROM_CTRL_ADDR, 32'(i * 16 + 8 + i % 4));
        end
        wr(EMB_SDCFG0_ADDR, 32'h0080_2881);
        chk(36'(resp), 36'(EMB_RESP_OKAY));
        wr(EMB_SDCFG1_ADDR, 32'h0100_1000);
        chk(36'(mrs_req), 36'h0);
        rchk(EMB_SDCFG0_ADDR, 32'h0080_2881);
        rchk(EMB_SDCFG1_ADDR, 32'h0100_1000);
        chk(bank_cfg[0], {32'h0040_0000, 1'b0, 2'h2, 1'b1});
        chk(bank_cfg[1], {32'h0080_0000, 1'b1, 2'h3, 1'b0});
        wr(EMB_SDCFG1_ADDR, 32'h0100_1800);
        rchk(EMB_SDCFG1_ADDR, 32'h0100_1000);
        wr(EMB_SDCFG1_ADDR, 32'h0100_0000);
        @(posedge clk);
        chk(36'(bank_cfg[1].cas_cycles), 36'h1);
        hchk(32'h0046_0000, 4'h7);
        hchk(32'h0048_0000, 4'h0);
        hchk(32'h003F_FFFF, 4'h0);
        hchk(32'h0082_0000, 4'h9);
        // frozen block keeps its last hit while the address moves
        ce <= 1'b0;
        hchk(32'h0046_0000, 4'h9);
        ce <= 1'b1;
        hchk(32'h0046_0000, 4'h7);
        // slow partner first, then a prompt one
        wr(EMB_SDCFG0_ADDR, 32'h0080_A881);
        chk(36'(mrs_req), 36'h1);
        repeat (15) @(posedge clk);
        chk(36'(mrs_req), 36'h0);
        rchk(EMB_SDCFG0_ADDR, 32'h0080_2881);
        ack_dly <= 4'h1;
        wr(EMB_SDCFG1_ADDR, 32'h0100_8000);
        chk(36'(mrs_req), 36'h2);
        repeat (6) @(posedge clk);
        chk(36'(mrs_req), 36'h0);
        wr(32'hB000_1000, 32'hFFFF_FFFF);
        chk(36'(resp), 36'(EMB_RESP_SLVERR));
        rdr(32'hB000_1000);
        chk({2'h0, resp, rd}, {2'h0, EMB_RESP_SLVERR, 32'h0});
        // byte lane 1 off: the mode set bit and byte 1 must not take
        wstrb <= 4'hD;
        wr(EMB_SDCFG0_ADDR, 32'h0080_B881);
        chk(36'(mrs_req), 36'h0);
        wstrb <= 4'hF;
        rchk(EMB_SDCFG0_ADDR, 32'h0080_2881);
        // reset in mid-run with a new strap level
        rst      <= 1'b1;
        boot_pin <= 2'h1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk(36'(rom_cfg.boot_width), 36'h1);
        rchk(EMB_SDCFG0_ADDR, EMB_SDCFG_RST);
        rchk(EMB_SDCFG1_ADDR, EMB_SDCFG_RST);
        rchk(EMB_ROM_CTRL_ADDR, 32'h4);
        report_and_stop();
    end
endmodule : ext_mem_bank_config_test
`default_nettype wire
